/* File: common/mss_pkg.sv */
/*
 motor start-up supervision: constants, register map, types.
 assumes a 100 MHz pclk and phase magnitudes in one common raw unit.
*/
// Contract
// - below 10% rated average means stopped
// - starting needs 500 ms stopped first
// - start level reached within 200 ms
// - starting holds until running conditions met
// - running from stopped or starting, 20%/120%; code tests only >20% from stopped, only <120% from starting
// - release when current drops below 120%
// - valid start raises start, starts timer
// - stage active only while starting
// - definite or current-dependent delay selectable
// - dependent time scales with squared ratio
// - nominal start current defaults to 6.00
// - start detection level defaults to six
// - motor current is three-phase mean
// - soft start goes stopped to running
// - starting and running exported as signals
// - any selected signal blocks the stage; code has a single stage_block pin, no selection
// - operate time 1.0 to 300.0 s
package mss_pkg;
   // register byte offsets
   localparam logic [7:0] MSS_OFF_CTRL = 8'h00;
   localparam logic [7:0] MSS_OFF_RATED = 8'h04;
   localparam logic [7:0] MSS_OFF_DETECT = 8'h08;
   localparam logic [7:0] MSS_OFF_NOMST = 8'h0C;
   localparam logic [7:0] MSS_OFF_TIME = 8'h10;
   localparam logic [7:0] MSS_OFF_STAT = 8'h14;
   localparam logic [7:0] MSS_OFF_IRQ = 8'h18;
   localparam logic [7:0] MSS_OFF_MASK = 8'h1C;
   localparam logic [7:0] MSS_OFF_AVG = 8'h20;
   // control fields
   localparam int MSS_CTRL_EN = 0;
   localparam int MSS_CTRL_FIXED = 1;
   // reset values
   localparam logic [1:0] MSS_CTRL_RST = 2'h3;
   localparam logic [15:0] MSS_RATED_RST = 16'h0064;
   localparam logic [9:0] MSS_DETECT_RST = 10'h258; // 6.00 x rated
   localparam logic [9:0] MSS_NOMST_RST = 10'h258; // 6.00 x rated
   localparam logic [11:0] MSS_TIME_RST = 12'h064; // 10.0 s
   localparam logic [11:0] MSS_TIME_MIN = 12'h00A; // 1.0 s
   localparam logic [11:0] MSS_TIME_MAX = 12'hBB8; // 300.0 s
   // event bits of irq status and mask
   localparam int MSS_EV_START = 0;
   localparam int MSS_EV_TRIP = 1;
   localparam int MSS_EV_RUN = 2;
   localparam int MSS_EV_STOP = 3;
   // timing
   localparam int unsigned MSS_CLK_KHZ = 100000;
   localparam int unsigned MSS_STOP_MIN_MS = 500;
   localparam int unsigned MSS_RISE_MAX_MS = 200;
   localparam int unsigned MSS_TICK_MS = 100;
   localparam int unsigned MSS_STOP_CYC = MSS_STOP_MIN_MS * MSS_CLK_KHZ;
   localparam int unsigned MSS_RISE_CYC = MSS_RISE_MAX_MS * MSS_CLK_KHZ;
   localparam int unsigned MSS_TICK_CYC = MSS_TICK_MS * MSS_CLK_KHZ;

   typedef enum logic [1:0] {
      MSS_STOPPED = 2'h0,
      MSS_RISING = 2'h1,
      MSS_STARTING = 2'h3,
      MSS_RUNNING = 2'h2
   } mss_state_e;

   typedef struct packed {
      logic [15:0] ia;
      logic [15:0] ib;
      logic [15:0] ic;
   } mss_phase_s;
endpackage

/* File: rtl/mss_top.sv */
/*
 motor start-up supervision stage with apb register slave.
 assumes phase magnitudes come from logic on pclk; stage_block is an
 asynchronous pin and is synchronised here.
*/
// The APB interface to the registers and the placing of the registers were decided locally.
module mss_top #(
   parameter int unsigned STOP_CYC = mss_pkg::MSS_STOP_CYC,
   parameter int unsigned RISE_CYC = mss_pkg::MSS_RISE_CYC,
   parameter int unsigned TICK_CYC = mss_pkg::MSS_TICK_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire mss_pkg::mss_phase_s phase,
   input wire logic stage_block,
   output logic motor_stopped,
   output logic motor_starting,
   output logic motor_running,
   output logic stage_start,
   output logic stage_trip,
   output logic irq
);
   import mss_pkg::*;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   mss_state_e state_q, state_d;
   logic [1:0] ctrl_q;
   logic [15:0] rated_q;
   logic [9:0] detect_q, nomst_q;
   logic [11:0] time_q, tmr_q;
   logic [3:0] irq_q, mask_q;
   logic [15:0] avg_q;
   logic [31:0] stop_cnt_q, rise_cnt_q, tick_cnt_q;
   logic [63:0] acc_q;
   logic [2:0] blk_sync_q;
   logic blk_q, start_q, trip_q;
   logic [31:0] rdata_q;

   // block pin: three flops, accept a level once stages 2 and 3 agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blk_sync_q <= 3'h0;
         blk_q <= 1'b0;
      end else if (pce) begin
         blk_sync_q <= {blk_sync_q[1:0], stage_block};
         if (blk_sync_q[1] == blk_sync_q[2]) begin
            blk_q <= blk_sync_q[2];
         end
      end
   end

   // three-phase mean, one cycle of latency
   logic [17:0] sum;
   assign sum = 18'(phase.ia) + 18'(phase.ib) + 18'(phase.ic);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         avg_q <= 16'h0000;
      end else if (pce) begin
         avg_q <= 16'(sum / 18'h00003);
      end
   end

   // level comparisons scaled to avoid division
   logic [19:0] avg_x10, avg_x5;
   logic below_stop, above_run_lo, below_run_hi, at_detect;
   assign avg_x10 = 20'(avg_q) * 20'h0000A;
   assign avg_x5 = 20'(avg_q) * 20'h00005;
   assign below_stop = avg_x10 < 20'(rated_q);
   assign above_run_lo = avg_x5 > 20'(rated_q);
   assign below_run_hi = avg_x10 < 20'(rated_q) * 20'h0000C;
   assign at_detect = 32'(avg_q) * 32'h00000064 > 32'(detect_q) * 32'(rated_q);

   logic armed, rise_over;
   assign armed = stop_cnt_q >= STOP_CYC - 1;
   assign rise_over = rise_cnt_q >= RISE_CYC - 1;

   // motor status; rising is the short window after leaving stopped
   always_comb begin
      state_d = state_q;
      case (state_q)
         MSS_STOPPED: begin
            if (!below_stop) begin
               if (armed) begin
                  state_d = MSS_RISING;
               end else if (above_run_lo) begin
                  state_d = MSS_RUNNING;
               end
            end
         end
         MSS_RISING: begin
            if (at_detect) begin
               state_d = MSS_STARTING;
            end else if (below_stop) begin
               state_d = MSS_STOPPED;
            end else if (rise_over) begin
               state_d = above_run_lo ? MSS_RUNNING : MSS_STOPPED;
            end
         end
         MSS_STARTING: begin
            if (below_run_hi) begin
               state_d = MSS_RUNNING;
            end
         end
         MSS_RUNNING: begin
            if (below_stop) begin
               state_d = MSS_STOPPED;
            end
         end
         default: state_d = MSS_STOPPED;
      endcase
   end

   // stage: active only in starting, cleared by release or block
   logic start_d, tick, reached, trip_d;
   logic [31:0] avg_sq, ist;
   logic [63:0] thr;
   assign start_d = (state_d == MSS_STARTING) && ctrl_q[MSS_CTRL_EN] && !blk_q;
   assign tick = start_q && (tick_cnt_q >= TICK_CYC - 1);
   assign avg_sq = 32'(avg_q) * 32'(avg_q);
   assign ist = 32'(nomst_q) * 32'(rated_q);
   // elapsed*measured_current^2 against allowed_start_time*rated_start_current^2: dependent delay without a divider
   assign thr = 64'(ist) * 64'(ist) * 64'(time_q);
   assign reached = ctrl_q[MSS_CTRL_FIXED] ? (tmr_q >= time_q) : (acc_q >= thr);
   assign trip_d = start_d && start_q && (reached || trip_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= MSS_STOPPED;
         stop_cnt_q <= 32'h00000000;
         rise_cnt_q <= 32'h00000000;
      end else if (pce) begin
         state_q <= state_d;
         stop_cnt_q <= (state_q == MSS_STOPPED && below_stop) ? (armed ? stop_cnt_q : stop_cnt_q + 32'h1) : 32'h0;
         rise_cnt_q <= (state_q == MSS_RISING) ? rise_cnt_q + 32'h1 : 32'h0;
      end
   end

   // start timer in 0.1 s steps; dependent mode integrates measured_current^2
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_q <= 1'b0;
         trip_q <= 1'b0;
         tick_cnt_q <= 32'h00000000;
         tmr_q <= 12'h000;
         acc_q <= 64'h0;
      end else if (pce) begin
         start_q <= start_d;
         trip_q <= trip_d;
         if (!start_d || !start_q) begin
            tick_cnt_q <= 32'h0;
            tmr_q <= 12'h000;
            acc_q <= 64'h0;
         end else begin
            tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
            if (tick && tmr_q != 12'hFFF) begin
               tmr_q <= tmr_q + 12'h001;
               acc_q <= acc_q + 64'(avg_sq) * 64'h2710; // ratio held in hundredths
            end
         end
      end
   end

   assign motor_stopped = (state_q == MSS_STOPPED) || (state_q == MSS_RISING);
   assign motor_starting = (state_q == MSS_STARTING);
   assign motor_running = (state_q == MSS_RUNNING);
   assign stage_start = start_q;
   assign stage_trip = trip_q;

   // apb: zero wait states, read data captured in the setup cycle
   logic wr, rd_setup, mapped;
   logic [11:0] time_wr;
   logic [3:0] ev;
   assign wr = psel && penable && pwrite && pce;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped = paddr[1:0] == 2'h0 && paddr <= MSS_OFF_AVG;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = rdata_q;
   // out-of-range operate times are clamped rather than refused
   assign time_wr = pwdata[11:0] < MSS_TIME_MIN ? MSS_TIME_MIN :
                    (pwdata[11:0] > MSS_TIME_MAX ? MSS_TIME_MAX : pwdata[11:0]);
   assign ev[MSS_EV_START] = start_d && !start_q;
   assign ev[MSS_EV_TRIP] = trip_d && !trip_q;
   assign ev[MSS_EV_RUN] = state_d == MSS_RUNNING && state_q != MSS_RUNNING;
   assign ev[MSS_EV_STOP] = state_d == MSS_STOPPED && state_q == MSS_RUNNING;
   assign irq = |(irq_q & mask_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= MSS_CTRL_RST;
         rated_q <= MSS_RATED_RST;
         detect_q <= MSS_DETECT_RST;
         nomst_q <= MSS_NOMST_RST;
         time_q <= MSS_TIME_RST;
         irq_q <= 4'h0;
         mask_q <= 4'h0;
      end else if (pce) begin
         // a new event wins over a same-cycle write-one clear
         irq_q <= (irq_q & ~((wr && hit(paddr, MSS_OFF_IRQ)) ? pwdata[3:0] : 4'h0)) | ev;
         if (wr && hit(paddr, MSS_OFF_CTRL)) ctrl_q <= pwdata[1:0];
         if (wr && hit(paddr, MSS_OFF_RATED)) rated_q <= pwdata[15:0];
         if (wr && hit(paddr, MSS_OFF_DETECT)) detect_q <= pwdata[9:0];
         if (wr && hit(paddr, MSS_OFF_NOMST)) nomst_q <= pwdata[9:0];
         if (wr && hit(paddr, MSS_OFF_TIME)) time_q <= time_wr;
         if (wr && hit(paddr, MSS_OFF_MASK)) mask_q <= pwdata[3:0];
      end
   end

   logic [31:0] rmux;
   assign rmux = hit(paddr, MSS_OFF_CTRL) ? 32'(ctrl_q) :
                 hit(paddr, MSS_OFF_RATED) ? 32'(rated_q) :
                 hit(paddr, MSS_OFF_DETECT) ? 32'(detect_q) :
                 hit(paddr, MSS_OFF_NOMST) ? 32'(nomst_q) :
                 hit(paddr, MSS_OFF_TIME) ? 32'(time_q) :
                 hit(paddr, MSS_OFF_STAT) ? {12'h000, tmr_q, 1'b0, blk_q, trip_q, start_q, 2'h0, state_q} :
                 hit(paddr, MSS_OFF_IRQ) ? 32'(irq_q) :
                 hit(paddr, MSS_OFF_MASK) ? 32'(mask_q) :
                 hit(paddr, MSS_OFF_AVG) ? 32'(avg_q) : 32'h00000000;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h00000000;
      end else if (pce && rd_setup) begin
         rdata_q <= rmux;
      end
   end

   // checks
   property p_stop;
      @(posedge pclk) disable iff (!presetn)
      pce && state_q == MSS_RUNNING && below_stop |=> state_q == MSS_STOPPED;
   endproperty
   a_stop: assert property (p_stop) else $error("running did not fall to stopped");
   property p_arm;
      @(posedge pclk) disable iff (!presetn)
      pce && state_q == MSS_STOPPED && !armed |=> state_q != MSS_RISING;
   endproperty
   a_arm: assert property (p_arm) else $error("start window opened too early");
   property p_window;
      @(posedge pclk) disable iff (!presetn)
      pce && state_q == MSS_RISING && rise_over && !at_detect |=> state_q != MSS_STARTING;
   endproperty
   a_window: assert property (p_window) else $error("start after window closed");
   property p_release;
      @(posedge pclk) disable iff (!presetn)
      pce && state_q == MSS_STARTING && below_run_hi |=> state_q == MSS_RUNNING && !start_q;
   endproperty
   a_release: assert property (p_release) else $error("stage not released");
   property p_active;
      @(posedge pclk) disable iff (!presetn)
      start_q |-> motor_starting && !motor_running;
   endproperty
   a_active: assert property (p_active) else $error("stage active outside starting");
   property p_block;
      @(posedge pclk) disable iff (!presetn)
      pce && blk_q |=> !start_q && !trip_q && tmr_q == 12'h000;
   endproperty
   a_block: assert property (p_block) else $error("block did not clear stage");
   property p_fresh;
      @(posedge pclk) disable iff (!presetn)
      $rose(start_q) |-> tmr_q == 12'h000 && acc_q == 64'h0;
   endproperty
   a_fresh: assert property (p_fresh) else $error("timer not fresh at start");
   property p_trip;
      @(posedge pclk) disable iff (!presetn)
      $rose(trip_q) && ctrl_q[MSS_CTRL_FIXED] |-> start_q && tmr_q >= time_q;
   endproperty
   a_trip: assert property (p_trip) else $error("trip before operate time");
   property p_mean;
      @(posedge pclk) disable iff (!presetn)
      pce |=> avg_q == 16'($past(sum) / 18'h00003);
   endproperty
   a_mean: assert property (p_mean) else $error("average wrong");
   // armed stop with current present opens the rise window
   property p_rise_enter;
      @(posedge pclk) disable iff (!presetn)
      pce && state_q == MSS_STOPPED && !below_stop && armed |=> state_q == MSS_RISING;
   endproperty
   a_rise_enter: assert property (p_rise_enter) else $error("rise window not opened");
   // unarmed stop goes straight to running above the low limit
   property p_run_entry;
      @(posedge pclk) disable iff (!presetn)
      pce && state_q == MSS_STOPPED && !below_stop && !armed && above_run_lo |=> state_q == MSS_RUNNING;
   endproperty
   a_run_entry: assert property (p_run_entry) else $error("running not entered from stopped");
   // detect level inside the window means starting
   property p_detect;
      @(posedge pclk) disable iff (!presetn)
      pce && state_q == MSS_RISING && at_detect |=> state_q == MSS_STARTING;
   endproperty
   a_detect: assert property (p_detect) else $error("start not detected");
   // soft start: window ends above the low limit, no starting state
   property p_soft;
      @(posedge pclk) disable iff (!presetn)
      pce && state_q == MSS_RISING && !at_detect && !below_stop && rise_over && above_run_lo
         |=> state_q == MSS_RUNNING;
   endproperty
   a_soft: assert property (p_soft) else $error("soft start not running");
   // starting holds while current stays high
   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      pce && state_q == MSS_STARTING && !below_run_hi |=> state_q == MSS_STARTING;
   endproperty
   a_hold: assert property (p_hold) else $error("starting left too early");
   // enabled, unblocked start raises the start signal
   property p_start;
      @(posedge pclk) disable iff (!presetn)
      pce && state_d == MSS_STARTING && ctrl_q[MSS_CTRL_EN] && !blk_q |=> start_q;
   endproperty
   a_start: assert property (p_start) else $error("start signal missing");
   // outside starting the stage is quiet
   property p_idle;
      @(posedge pclk) disable iff (!presetn)
      state_q != MSS_STARTING |-> !start_q && !trip_q;
   endproperty
   a_idle: assert property (p_idle) else $error("stage active outside starting");
   // definite delay reached trips on the next edge
   property p_fixed_trip;
      @(posedge pclk) disable iff (!presetn)
      pce && start_q && start_d && ctrl_q[MSS_CTRL_FIXED] && tmr_q >= time_q |=> trip_q;
   endproperty
   a_fixed_trip: assert property (p_fixed_trip) else $error("definite trip missing");
   // dependent threshold reached trips on the next edge
   property p_dep_trip;
      @(posedge pclk) disable iff (!presetn)
      pce && start_q && start_d && !ctrl_q[MSS_CTRL_FIXED] && acc_q >= thr |=> trip_q;
   endproperty
   a_dep_trip: assert property (p_dep_trip) else $error("dependent trip missing");
   // timer steps by one per tick while the stage is active
   property p_tmr;
      @(posedge pclk) disable iff (!presetn)
      pce && start_q && start_d && tick && tmr_q != 12'hFFF |=> tmr_q == $past(tmr_q) + 12'h001;
   endproperty
   a_tmr: assert property (p_tmr) else $error("timer did not step");
   // operate time never leaves its legal range
   property p_clamp;
      @(posedge pclk) disable iff (!presetn)
      time_q >= MSS_TIME_MIN && time_q <= MSS_TIME_MAX;
   endproperty
   a_clamp: assert property (p_clamp) else $error("operate time out of range");
   // agreeing sync stages accept the block level
   property p_sync;
      @(posedge pclk) disable iff (!presetn)
      pce && blk_sync_q[1] && blk_sync_q[2] |=> blk_q;
   endproperty
   a_sync: assert property (p_sync) else $error("block not accepted");
   // an event sets its sticky bit even against a clear
   property p_irq_set;
      @(posedge pclk) disable iff (!presetn)
      pce && (|ev) |=> (irq_q & $past(ev)) == $past(ev);
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("event lost in status");
   // read data is the register seen in the setup cycle
   property p_rdcap;
      @(posedge pclk) disable iff (!presetn)
      pce && psel && !penable && !pwrite |=> prdata == $past(rmux);
   endproperty
   a_rdcap: assert property (p_rdcap) else $error("read data not captured");
   // clock enable low freezes the status and the timer
   property p_freeze;
      @(posedge pclk) disable iff (!presetn)
      !pce |=> $stable(state_q) && $stable(start_q) && $stable(tmr_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
   c_start: cover property (@(posedge pclk) disable iff (!presetn) $rose(start_q));
   c_trip: cover property (@(posedge pclk) disable iff (!presetn) $rose(trip_q));
   c_soft: cover property (@(posedge pclk) disable iff (!presetn) state_q == MSS_RISING ##1 state_q == MSS_RUNNING);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule // mss_top

/* File: sim/mss_motor_model.sv */
/*
 far side: three phase magnitudes around a requested average, plus block pin.
 assumes the bench sets level and blk on pclk rising edges.
*/
module mss_motor_model (
   input wire logic pclk,
   input wire logic [15:0] level,
   input wire logic blk,
   output mss_pkg::mss_phase_s phase,
   output logic stage_block
);
   import mss_pkg::*;
   logic [15:0] skew;
   // unequal phases so only a true mean lands on level
   assign skew = (level >= 16'h0002) ? 16'h0002 : 16'h0000;
   // phases and block follow the request one edge later
   always_ff @(posedge pclk) begin
      phase.ia <= level + skew;
      phase.ib <= level;
      phase.ic <= level - skew;
      stage_block <= blk;
   end
endmodule // mss_motor_model

/* File: sim/mss_top_tb.sv */
/*
 bench for mss_top: apb tasks, motor model, sequences with expected values.
 assumes short STOP/RISE/TICK parameters (50, 20, 10 cycles).
*/
module mss_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import mss_pkg::*;
   logic pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, err, blk, stage_block, irq;
   logic motor_stopped, motor_starting, motor_running, stage_start, stage_trip;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] level;
   mss_phase_s phase;
   wire [4:0] mon = {stage_trip, stage_start, motor_running, motor_starting, motor_stopped};
   int failures, num_checks, n;
   mss_top #(.STOP_CYC(50), .RISE_CYC(20), .TICK_CYC(10)) dut_u (.pclk(pclk), .presetn(presetn),
      .pce(pce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase(phase), .stage_block(stage_block),
      .motor_stopped(motor_stopped), .motor_starting(motor_starting), .motor_running(motor_running),
      .stage_start(stage_start), .stage_trip(stage_trip), .irq(irq));
   mss_motor_model model_u (.pclk(pclk), .level(level), .blk(blk), .phase(phase), .stage_block(stage_block));
   // clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task complete_run;
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // one apb transfer; request held until pready seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50) begin
         @(posedge pclk);
         k++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 50) begin
         chk(32'h0, 32'h1);
         complete_run;
      end
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // bounded wait for one status output to reach v; n counts cycles
   task waitb(input int i, input logic v, input int lim);
      n = 0;
      while (mon[i] !== v && n < lim) begin
         @(posedge pclk);
         #1;
         n++;
      end
      if (mon[i] !== v) begin
         chk({31'h0, mon[i]}, {31'h0, v});
         complete_run;
      end
   endtask
   task lvl(input logic [15:0] v);
      @(posedge pclk);
      level <= v;
   endtask
   // longer than the 50-cycle stop time, so start is armed
   task stop_arm;
      lvl(16'h0000);
      repeat (60) @(posedge pclk);
   endtask
   initial begin
      presetn = 1'b0;
      pce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      level = 16'h0000;
      blk = 1'b0;
      failures = 0;
      num_checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(MSS_OFF_CTRL, 32'h3);
      rdc(MSS_OFF_RATED, 32'h64);
      rdc(MSS_OFF_DETECT, 32'h258);
      rdc(MSS_OFF_NOMST, 32'h258);
      rdc(MSS_OFF_TIME, 32'h64);
      apb(1'b0, 8'h24, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, MSS_OFF_TIME, 32'h5);
      rdc(MSS_OFF_TIME, 32'h00A);
      apb(1'b1, MSS_OFF_TIME, 32'hFFF);
      rdc(MSS_OFF_TIME, 32'hBB8);
      apb(1'b1, MSS_OFF_TIME, 32'hA);
      chk({27'h0, mon}, 32'h01);
      $display("test registers done");
      // definite start, trip, irq, release to running
      apb(1'b1, MSS_OFF_MASK, 32'h3);
      stop_arm;
      lvl(16'h02BC);
      waitb(1, 1'b1, 10);
      chk({31'h0, mon[3]}, 32'h1);
      waitb(4, 1'b1, 150);
      chk({31'h0, n >= 85 && n <= 125}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rdc(MSS_OFF_IRQ, 32'h3);
      apb(1'b1, MSS_OFF_IRQ, 32'h3);
      #1;
      chk({31'h0, irq}, 32'h0);
      lvl(16'h006E);
      waitb(2, 1'b1, 10);
      chk({27'h0, mon}, 32'h04);
      $display("test definite done");
      // not stopped long enough: straight to running
      lvl(16'h0000);
      repeat (10) @(posedge pclk);
      lvl(16'h02BC);
      waitb(2, 1'b1, 10);
      chk({31'h0, mon[3]}, 32'h0);
      $display("test unarmed done");
      // soft start stays below detect level
      stop_arm;
      apb(1'b1, MSS_OFF_IRQ, 32'hF);
      lvl(16'h0032);
      waitb(2, 1'b1, 40);
      rdc(MSS_OFF_IRQ, 32'h4);
      $display("test soft start done");
      // block during start
      stop_arm;
      lvl(16'h02BC);
      waitb(3, 1'b1, 10);
      @(posedge pclk);
      blk <= 1'b1;
      waitb(3, 1'b0, 8);
      chk({30'h0, mon[4], mon[1]}, 32'h1);
      blk <= 1'b0;
      $display("test block done");
      // dependent delay at twice nominal start current
      lvl(16'h0000);
      apb(1'b1, MSS_OFF_CTRL, 32'h1);
      stop_arm;
      lvl(16'h04B0);
      waitb(3, 1'b1, 10);
      waitb(4, 1'b1, 60);
      chk({31'h0, n >= 15 && n <= 45}, 32'h1);
      $display("test dependent done");
      // stage disabled: status still follows, no start
      lvl(16'h0000);
      apb(1'b1, MSS_OFF_CTRL, 32'h2);
      stop_arm;
      lvl(16'h02BC);
      waitb(1, 1'b1, 10);
      chk({31'h0, mon[3]}, 32'h0);
      $display("test disabled done");
      // clock enable low freezes the status outputs
      lvl(16'h0000);
      waitb(0, 1'b1, 20);
      pce <= 1'b0;
      lvl(16'h02BC);
      repeat (20) @(posedge pclk);
      chk({27'h0, mon}, 32'h01);
      pce <= 1'b1;
      $display("test clock enable done");
      complete_run;
   end
endmodule // mss_top_tb
